/* File: design/drs_sequencer.sv */
// disturbance record sequencer with wishbone registers
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - capture starts only when trigger is true and recorder enabled
// - capture continues while trigger held, never beyond the limit
// - at most 64 binary and 32 analog channels selected
// - twelve megabytes of record storage
// - base variant takes twenty samples per network period
// - rate setting selects twenty or forty samples per period
// - records include history samples preceding the trigger
// - fault section ends at limit or trigger release, whichever first
// - trailing section follows fault section in the same record
// - trigger must deassert before a new capture starts (the code also re-arms when the recorder is disabled with the trigger held)
// - records are laid out as configuration, data and comment files
// - storage estimate uses 7 kB analog, 2 kB binary per second
// - warning when history plus trailing exceeds the limit
module drs_sequencer
  import drs_pkg::*;
#(
  parameter int MS_CYC = DRS_MS_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        capture_trigger_in_i,
  output logic             sample_strobe_o,
  output logic             record_active_o,
  output logic             record_done_o,
  output logic             warning_o,
  output logic             irq_o
);
  drs_tick_if tk ();

  drs_tick_gen #(
    .MS_CYC (MS_CYC)
  ) u_tick (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tk    (tk)
  );

  // size estimate in kB per second of record
  function automatic logic [15:0] est_kb(input logic [5:0] n_ana, input logic [6:0] n_bin);
    est_kb = 16'(n_ana) * 16'(DRS_KB_ANA) + 16'(n_bin) * 16'(DRS_KB_BIN);
  endfunction : est_kb

  // clamp a channel count to its maximum
  function automatic logic [6:0] clamp_ch(input logic [6:0] v, input logic [6:0] mx);
    clamp_ch = (v > mx) ? mx : v;
  endfunction : clamp_ch

  drs_state_type        state_reg;
  logic                 recorder_enable_setting_reg;
  logic                 rate_select_setting_reg;
  logic [DRS_MS_W-1:0]  history_duration_setting_reg;
  logic [DRS_MS_W-1:0]  trailing_duration_setting_reg;
  logic [DRS_MS_W-1:0]  capture_limit_setting_reg;
  logic [5:0]           ana_cnt_reg;
  logic [6:0]           bin_cnt_reg;
  logic [23:0]          period_reg;
  logic [DRS_IRQ_W-1:0] irq_stat_reg;
  logic [DRS_IRQ_W-1:0] irq_mask_reg;
  logic [DRS_MS_W-1:0]  ms_cnt_reg;
  logic [DRS_MS_W:0]    fault_ms_reg;
  logic [DRS_ADDR_W-1:0] wptr_reg;
  logic [DRS_ADDR_W-1:0] start_ptr_reg;
  logic [DRS_ADDR_W-1:0] sample_cnt_reg;
  logic [DRS_ADDR_W-1:0] rec_len_reg;
  logic                 qual_prev_reg;

  // bus decode
  logic wb_req;
  logic wb_wr;
  logic wr_ctrl;
  logic wr_hist;
  logic wr_trail;
  logic wr_limit;
  logic wr_chan;
  logic wr_irq;
  logic wr_mask;
  logic wr_period;
  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr     = wb_req && wb_we_i;
  assign wr_ctrl   = wb_wr && wb_adr_i == DRS_CTRL_OFS   && wb_sel_i[0];
  assign wr_hist   = wb_wr && wb_adr_i == DRS_HIST_OFS   && &wb_sel_i[1:0];
  assign wr_trail  = wb_wr && wb_adr_i == DRS_TRAIL_OFS  && &wb_sel_i[1:0];
  assign wr_limit  = wb_wr && wb_adr_i == DRS_LIMIT_OFS  && &wb_sel_i[1:0];
  assign wr_chan   = wb_wr && wb_adr_i == DRS_CHAN_OFS   && &wb_sel_i[1:0];
  assign wr_irq    = wb_wr && wb_adr_i == DRS_IRQ_OFS    && wb_sel_i[0];
  assign wr_mask   = wb_wr && wb_adr_i == DRS_MASK_OFS   && wb_sel_i[0];
  assign wr_period = wb_wr && wb_adr_i == DRS_PERIOD_OFS && &wb_sel_i[2:0];

  // trigger qualification and edge detection
  logic qual_trig;
  logic start_evt;
  logic settings_bad;
  logic hist_full;
  logic fault_end;
  logic trail_end;
  assign qual_trig    = capture_trigger_in_i && recorder_enable_setting_reg;
  assign start_evt    = state_reg == DRS_IDLE && qual_trig && !qual_prev_reg;
  assign settings_bad = ({1'b0, history_duration_setting_reg}
                        + {1'b0, trailing_duration_setting_reg})
                        > {1'b0, capture_limit_setting_reg};
  assign hist_full    = ms_cnt_reg >= history_duration_setting_reg;
  assign fault_end    = !capture_trigger_in_i
                        || fault_ms_reg >= {1'b0, capture_limit_setting_reg};
  assign trail_end    = ms_cnt_reg >= trailing_duration_setting_reg;

  // tick generator controls
  assign tk.rate_high  = rate_select_setting_reg;
  assign tk.period_cyc = period_reg;

  // next irq status: set wins over write-one-clear
  logic [DRS_IRQ_W-1:0] irq_set;
  logic [DRS_IRQ_W-1:0] irq_stat_next;
  assign irq_set[DRS_IRQ_START_BIT] = start_evt;
  assign irq_set[DRS_IRQ_DONE_BIT]  = state_reg == DRS_TRAIL && tk.ms_tick && trail_end;
  assign irq_set[DRS_IRQ_WARN_BIT]  = settings_bad && !warning_o;
  assign irq_stat_next = (irq_stat_reg & ~(wr_irq ? wb_dat_i[DRS_IRQ_W-1:0] : '0)) | irq_set;

  // read mux
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = '0;
    case (wb_adr_i)
      DRS_CTRL_OFS:   rd_data = {30'h0, rate_select_setting_reg, recorder_enable_setting_reg};
      DRS_HIST_OFS:   rd_data = 32'(history_duration_setting_reg);
      DRS_TRAIL_OFS:  rd_data = 32'(trailing_duration_setting_reg);
      DRS_LIMIT_OFS:  rd_data = 32'(capture_limit_setting_reg);
      DRS_CHAN_OFS:   rd_data = {est_kb(ana_cnt_reg, bin_cnt_reg), 1'b0, bin_cnt_reg,
                                 2'b00, ana_cnt_reg};
      DRS_STAT_OFS:   rd_data = {28'h0, warning_o, 1'b0, 2'(state_reg)};
      DRS_IRQ_OFS:    rd_data = 32'(irq_stat_reg);
      DRS_MASK_OFS:   rd_data = 32'(irq_mask_reg);
      DRS_PERIOD_OFS: rd_data = 32'(period_reg);
      DRS_WPTR_OFS:   rd_data = 32'(wptr_reg);
      DRS_START_OFS:  rd_data = 32'(start_ptr_reg);
      DRS_LEN_OFS:    rd_data = 32'(rec_len_reg);
      default:        rd_data = '0;
    endcase
  end

  // wishbone answer, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : '0;
    end
  end

  // setting registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      recorder_enable_setting_reg   <= 1'b0;
      rate_select_setting_reg       <= 1'b0;
      history_duration_setting_reg  <= DRS_HIST_DEF;
      trailing_duration_setting_reg <= DRS_TRAIL_DEF;
      capture_limit_setting_reg     <= DRS_LIMIT_DEF;
      ana_cnt_reg                   <= '0;
      bin_cnt_reg                   <= '0;
      period_reg                    <= DRS_PERIOD_DEF;
      irq_mask_reg                  <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        recorder_enable_setting_reg <= wb_dat_i[DRS_CTRL_EN_BIT];
        rate_select_setting_reg     <= wb_dat_i[DRS_CTRL_RATE_BIT];
      end
      if (wr_hist)
        history_duration_setting_reg <= wb_dat_i[DRS_MS_W-1:0];
      if (wr_trail)
        trailing_duration_setting_reg <= wb_dat_i[DRS_MS_W-1:0];
      if (wr_limit)
        capture_limit_setting_reg <= wb_dat_i[DRS_MS_W-1:0];
      if (wr_chan)
      begin
        ana_cnt_reg <= 6'(clamp_ch({1'b0, wb_dat_i[5:0]}, 7'(DRS_MAX_ANA)));
        bin_cnt_reg <= clamp_ch(wb_dat_i[14:8], 7'(DRS_MAX_BIN));
      end
      if (wr_mask)
        irq_mask_reg <= wb_dat_i[DRS_IRQ_W-1:0];
      if (wr_period)
        period_reg <= wb_dat_i[23:0];
    end
  end

  // capture sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg     <= DRS_IDLE;
      qual_prev_reg <= 1'b0;
      ms_cnt_reg    <= '0;
      fault_ms_reg  <= '0;
    end
    else
    begin
      qual_prev_reg <= qual_trig;
      case (state_reg)
        DRS_IDLE:
        begin
          if (tk.ms_tick && !hist_full)
            ms_cnt_reg <= ms_cnt_reg + 1'b1; // history fill
          if (start_evt)
          begin
            state_reg    <= DRS_FAULT;
            fault_ms_reg <= '0;
          end
        end
        DRS_FAULT:
        begin
          if (tk.ms_tick)
            fault_ms_reg <= fault_ms_reg + 1'b1;
          if (fault_end)
          begin
            state_reg  <= DRS_TRAIL;
            ms_cnt_reg <= '0;
          end
        end
        DRS_TRAIL:
        begin
          if (tk.ms_tick)
          begin
            if (trail_end)
            begin
              state_reg  <= DRS_REARM;
              ms_cnt_reg <= '0;
            end
            else
              ms_cnt_reg <= ms_cnt_reg + 1'b1;
          end
        end
        DRS_REARM:
        begin
          if (!qual_trig)
            state_reg <= DRS_IDLE;
        end
        default:
          state_reg <= DRS_IDLE;
      endcase
    end
  end

  // ring storage pointers and record bounds
  logic                  capturing;
  logic [DRS_ADDR_W-1:0] wptr_inc;
  assign capturing = state_reg == DRS_FAULT || state_reg == DRS_TRAIL;
  assign wptr_inc  = (wptr_reg == DRS_ADDR_W'(DRS_STORE_B - 1)) ? '0 : wptr_reg + 1'b1;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_reg       <= '0;
      start_ptr_reg  <= '0;
      sample_cnt_reg <= '0;
      rec_len_reg    <= '0;
    end
    else
    begin
      if (tk.sample_tick)
        wptr_reg <= wptr_inc; // history runs continuously
      if (start_evt)
        start_ptr_reg <= wptr_reg; // history section lies behind this point
      if (start_evt)
        sample_cnt_reg <= '0;
      else if (capturing && tk.sample_tick)
        sample_cnt_reg <= sample_cnt_reg + 1'b1;
      if (irq_set[DRS_IRQ_DONE_BIT])
        rec_len_reg <= sample_cnt_reg; // closes record for cfg/dat export
    end
  end

  // outputs and interrupt status
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_reg    <= '0;
      irq_o           <= 1'b0;
      warning_o       <= 1'b0;
      sample_strobe_o <= 1'b0;
      record_active_o <= 1'b0;
      record_done_o   <= 1'b0;
    end
    else
    begin
      irq_stat_reg    <= irq_stat_next;
      irq_o           <= |(irq_stat_next & irq_mask_reg);
      warning_o       <= settings_bad;
      sample_strobe_o <= tk.sample_tick;
      // falls together with the done pulse
      record_active_o <= (capturing && !irq_set[DRS_IRQ_DONE_BIT]) || start_evt;
      record_done_o   <= irq_set[DRS_IRQ_DONE_BIT];
    end
  end
endmodule : drs_sequencer
`default_nettype wire

/* File: design/drs_pkg.sv */
// package for the disturbance record sequencer
package drs_pkg;
  // register byte offsets
  localparam logic [7:0] DRS_CTRL_OFS    = 8'h00;
  localparam logic [7:0] DRS_HIST_OFS    = 8'h04;
  localparam logic [7:0] DRS_TRAIL_OFS   = 8'h08;
  localparam logic [7:0] DRS_LIMIT_OFS   = 8'h0c;
  localparam logic [7:0] DRS_CHAN_OFS    = 8'h10;
  localparam logic [7:0] DRS_STAT_OFS    = 8'h14;
  localparam logic [7:0] DRS_IRQ_OFS     = 8'h18;
  localparam logic [7:0] DRS_MASK_OFS    = 8'h1c;
  localparam logic [7:0] DRS_PERIOD_OFS  = 8'h20;
  localparam logic [7:0] DRS_WPTR_OFS    = 8'h24;
  localparam logic [7:0] DRS_START_OFS   = 8'h28;
  localparam logic [7:0] DRS_LEN_OFS     = 8'h2c;
  // control fields
  localparam int DRS_CTRL_EN_BIT   = 0;
  localparam int DRS_CTRL_RATE_BIT = 1;
  // irq bits
  localparam int DRS_IRQ_START_BIT = 0;
  localparam int DRS_IRQ_DONE_BIT  = 1;
  localparam int DRS_IRQ_WARN_BIT  = 2;
  localparam int DRS_IRQ_W         = 3;
  // time settings in ms, defaults
  localparam logic [13:0] DRS_HIST_DEF  = 14'h00c8;
  localparam logic [13:0] DRS_TRAIL_DEF = 14'h00c8;
  localparam logic [13:0] DRS_LIMIT_DEF = 14'h03e8;
  localparam int          DRS_MS_W      = 14;
  // channel limits and storage
  localparam int DRS_MAX_BIN    = 64;
  localparam int DRS_MAX_ANA    = 32;
  localparam int DRS_STORE_MB   = 12;
  localparam int DRS_STORE_B    = DRS_STORE_MB * 1024 * 1024;
  localparam int DRS_ADDR_W     = 24;
  localparam int DRS_KB_ANA     = 7;
  localparam int DRS_KB_BIN     = 2;
  // sampling per network period
  localparam logic [5:0] DRS_SPP_LOW  = 6'h14;
  localparam logic [5:0] DRS_SPP_HIGH = 6'h28;
  // clock rate, network period default (50 Hz)
  localparam int          DRS_CLK_HZ     = 250000000;
  localparam int          DRS_MS_CYC     = DRS_CLK_HZ / 1000;
  localparam logic [23:0] DRS_PERIOD_DEF = 24'h4c4b40;
  // sequencer states
  typedef enum logic [2:0] {
    DRS_IDLE, DRS_FAULT, DRS_TRAIL, DRS_REARM
  } drs_state_type;
endpackage : drs_pkg

/* File: design/drs_tick_if.sv */
// sample tick bundle between sequencer and tick generator
`timescale 1ns/1ps
`default_nettype none
interface drs_tick_if;
  logic        rate_high;
  logic [23:0] period_cyc;
  logic        sample_tick;
  logic        ms_tick;
  modport gen (input rate_high, input period_cyc, output sample_tick, output ms_tick);
  modport seq (output rate_high, output period_cyc, input sample_tick, input ms_tick);
endinterface : drs_tick_if
`default_nettype wire

/* File: design/drs_tick_gen.sv */
// sample and millisecond tick generator
`timescale 1ns/1ps
`default_nettype none
module drs_tick_gen
  import drs_pkg::*;
#(
  parameter int MS_CYC = DRS_MS_CYC
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  drs_tick_if.gen   tk
);
  logic [23:0] samp_cnt_reg;
  logic [23:0] samp_step;
  logic [24:0] samp_sum;
  logic [17:0] ms_cnt_reg;
  logic        samp_stale;
  logic        samp_wrap;
  logic        ms_wrap;

  // period cycles times samples per period, accumulated
  assign samp_step  = tk.rate_high ? 24'(DRS_SPP_HIGH) : 24'(DRS_SPP_LOW);
  assign samp_sum   = {1'b0, samp_cnt_reg} + {1'b0, samp_step};
  // left over after the period shrank: restart instead of a strobe burst
  assign samp_stale = samp_cnt_reg >= tk.period_cyc;
  assign samp_wrap  = !samp_stale && (samp_sum >= {1'b0, tk.period_cyc});
  assign ms_wrap    = (ms_cnt_reg == 18'(MS_CYC - 1));

  // fractional sample rate accumulator and ms divider
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      samp_cnt_reg   <= '0;
      ms_cnt_reg     <= '0;
      tk.sample_tick <= 1'b0;
      tk.ms_tick     <= 1'b0;
    end
    else
    begin
      if (samp_stale)
        samp_cnt_reg <= '0;
      else if (samp_wrap)
        samp_cnt_reg <= 24'(samp_sum - {1'b0, tk.period_cyc});
      else
        samp_cnt_reg <= samp_sum[23:0];
      ms_cnt_reg     <= ms_wrap ? '0 : ms_cnt_reg + 18'h1;
      tk.sample_tick <= samp_wrap;
      tk.ms_tick     <= ms_wrap;
    end
  end
endmodule : drs_tick_gen
`default_nettype wire

/* File: bench/drs_sequencer_props.sv */
// port checker for the record sequencer
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer_props (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        capture_trigger_in_i,
  input  wire logic        sample_strobe_o,
  input  wire logic        record_active_o,
  input  wire logic        record_done_o,
  input  wire logic        warning_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic low_seen_reg;
  // trigger seen low since the last record ended
  always_ff @(posedge clk_i)
    if (rst_i || !capture_trigger_in_i)
      low_seen_reg <= 1'b1;
    else if (record_done_o)
      low_seen_reg <= 1'b0;
  // bus answer timing
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acknowledged");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  // record start, end and re-arm, sample strobe spacing and warning
  property p_start; $rose(record_active_o) |-> $past(capture_trigger_in_i); endproperty
  a_start: assert property (p_start) else $error("record without trigger");
  property p_rearm; $rose(record_active_o) |-> low_seen_reg; endproperty
  a_rearm: assert property (p_rearm) else $error("restart without release");
  property p_done_end; record_done_o |-> !record_active_o && $past(record_active_o); endproperty
  a_done_end: assert property (p_done_end) else $error("done not at record end");
  property p_done_pulse; record_done_o |=> !record_done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_strobe; sample_strobe_o |=> !sample_strobe_o [*8]; endproperty
  a_strobe: assert property (p_strobe) else $error("sample strobes too close");
  property p_warn;
    $changed(warning_o) |-> $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2);
  endproperty
  a_warn: assert property (p_warn) else $error("warning moved without write");
  c_rec: cover property ($rose(record_active_o));
  c_done: cover property (record_done_o && capture_trigger_in_i);
  c_warn: cover property ($rose(warning_o));
endmodule : drs_sequencer_props
`default_nettype wire

/* File: bench/drs_trigger_src.sv */
// trigger source model standing in for user trigger logic
`timescale 1ns/1ps
`default_nettype none
module drs_trigger_src (
  input  wire logic want_i,
  input  wire logic clk_i,
  input  wire logic rst_i,
  output var  logic capture_trigger_in_o
);
  // registered like user logic; released low before any re-trigger
  always_ff @(posedge clk_i)
    if (rst_i)
      capture_trigger_in_o <= 1'b0;
    else
      capture_trigger_in_o <= want_i;
endmodule : drs_trigger_src
`default_nettype wire

/* File: bench/test_drs_sequencer.sv */
// self-checking bench for the record sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module test_drs_sequencer;
  import drs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        want = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, trig, strobe, active, done, warn, irq;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  drs_trigger_src i_src (.clk_i, .rst_i, .want_i(want), .capture_trigger_in_o(trig));
  drs_sequencer #(.MS_CYC(100)) i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
    .capture_trigger_in_i(trig), .sample_strobe_o(strobe), .record_active_o(active),
    .record_done_o(done), .warning_o(warn), .irq_o(irq));
  initial
    forever #2 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic t_regs;
    rchk(DRS_CTRL_OFS, 32'h0);
    rchk(DRS_HIST_OFS, 32'h0000_00c8);
    rchk(DRS_LIMIT_OFS, 32'h0000_03e8);
    rchk(DRS_PERIOD_OFS, 32'h004c_4b40);
    wb(1'b1, 8'h30, 32'hffff_ffff);
    rchk(8'h30, 32'h0);
    wb(1'b1, DRS_CHAN_OFS, 32'hffff_4628);
    rchk(DRS_CHAN_OFS, 32'h0160_4020);
  endtask : t_regs
  task automatic t_warn;
    wb(1'b1, DRS_HIST_OFS, 32'h64);
    wb(1'b1, DRS_TRAIL_OFS, 32'h64);
    wb(1'b1, DRS_LIMIT_OFS, 32'h64);
    tick(2);
    `CHK(warn, 1'b1)
    rchk(DRS_STAT_OFS, 32'h8);
    rchk(DRS_IRQ_OFS, 32'h4);
    wb(1'b1, DRS_MASK_OFS, 32'h4);
    tick(2);
    `CHK(irq, 1'b1)
    wb(1'b1, DRS_IRQ_OFS, 32'h4);
    tick(2);
    `CHK(irq, 1'b0)
    wb(1'b1, DRS_LIMIT_OFS, 32'h3e8);
    tick(2);
    `CHK(warn, 1'b0)
  endtask : t_warn
  task automatic wait_strobe;
    do @(posedge clk_i); while (strobe !== 1'b1);
  endtask : wait_strobe
  task automatic t_rate;
    int n;
    wb(1'b1, DRS_PERIOD_OFS, 32'h190);
    for (int r = 0; r < 2; r++)
    begin
      wb(1'b1, DRS_CTRL_OFS, {30'h0, r[0], 1'b1});
      wait_strobe();
      wait_strobe();
      n = 0;
      do begin @(posedge clk_i); n++; end while (strobe !== 1'b1);
      `CHK(n, 20 >> r)
    end
  endtask : t_rate
  task automatic t_rec;
    wb(1'b1, DRS_CTRL_OFS, 32'h0);
    want <= 1'b1;
    tick(6);
    `CHK(active, 1'b0)
    want <= 1'b0;
    wb(1'b1, DRS_IRQ_OFS, 32'h7);
    wb(1'b1, DRS_HIST_OFS, 32'h0);
    wb(1'b1, DRS_TRAIL_OFS, 32'h2);
    wb(1'b1, DRS_MASK_OFS, 32'h2);
    wb(1'b1, DRS_CTRL_OFS, 32'h1);
    want <= 1'b1;
    tick(3);
    `CHK(active, 1'b1)
    rchk(DRS_STAT_OFS, 32'h1);
    rchk(DRS_IRQ_OFS, 32'h1);
    want <= 1'b0;
    tick(4);
    rchk(DRS_STAT_OFS, 32'h2);
    while (done !== 1'b1) @(posedge clk_i);
    tick(2);
    `CHK(irq, 1'b1)
    rchk(DRS_IRQ_OFS, 32'h3);
    wb(1'b1, DRS_IRQ_OFS, 32'h3);
    tick(2);
    `CHK(irq, 1'b0)
  endtask : t_rec
  task automatic t_hold;
    wb(1'b1, DRS_LIMIT_OFS, 32'h2);
    want <= 1'b1;
    while (done !== 1'b1) @(posedge clk_i);
    tick(8);
    `CHK(active, 1'b0)
    rchk(DRS_STAT_OFS, 32'h3);
    want <= 1'b0;
    tick(3);
    want <= 1'b1;
    tick(4);
    `CHK(active, 1'b1)
    want <= 1'b0;
    while (done !== 1'b1) @(posedge clk_i);
  endtask : t_hold
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_warn();
    t_rate();
    t_rec();
    t_hold();
    end_of_test();
  end
endmodule : test_drs_sequencer
bind drs_sequencer drs_sequencer_props i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .capture_trigger_in_i, .sample_strobe_o,
  .record_active_o, .record_done_o, .warning_o);
`default_nettype wire
